// >>> rsf_regs.svh
// Register map, field positions, reset values and timing counts of the reset-source flag block
`ifndef RSF_REGS_SVH
`define RSF_REGS_SVH

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define RSF_OFF_FLAGS 8'h00
`define RSF_OFF_STATUS 8'h04
`define RSF_OFF_LVL 8'h08
`define RSF_OFF_RFC 8'h0c
`define RSF_OFF_FC1 8'h10
`define RSF_OFF_IRQ_STAT 8'h14
`define RSF_OFF_IRQ_EN 8'h18
`define RSF_OFF_IRQ_CLR 8'h1c
`define RSF_OFF_KIND 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSF_BIT_WCFG 0
`define RSF_BIT_BCFG 1
`define RSF_BIT_BOR 2
`define RSF_BIT_RCFG 3
`define RSF_IRQ_W 5

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RSF_LVL_POR 8'h66
`define RSF_LVL_OFF 8'hf0
`define RSF_RFC_IO 8'h55
`define RSF_RFC_PIN 8'haa
`define RSF_FC1_KEY 8'h55
`define RSF_PORT_POR 8'hff

// ----------------------------------------
// Timing counts in CORE_CLK cycles
// ----------------------------------------
`define RSF_SRESET_CYC 8'h08
`define RSF_LVR_QUAL_CYC 8'h04
`define RSF_HOLD_CYC 8'h04

`endif

// >>> rsf_pkg.sv
// Types shared by the reset-source flag block
package rsf_pkg;
	typedef enum logic [2:0] {
		RSF_KIND_NONE = 3'b000,
		RSF_KIND_POR = 3'b001,
		RSF_KIND_PIN = 3'b010,
		RSF_KIND_BOR = 3'b011,
		RSF_KIND_WDT_RUN = 3'b100,
		RSF_KIND_WDT_SLEEP = 3'b101,
		RSF_KIND_SOFT = 3'b110,
		RSF_KIND_IAP = 3'b111
	} rsf_kind_t;

	typedef enum logic [1:0] {
		RSF_SEQ_IDLE = 2'b00,
		RSF_SEQ_DELAY = 2'b01,
		RSF_SEQ_HOLD = 2'b10
	} rsf_seq_t;

	typedef struct packed {
		logic rcfg;
		logic bor;
		logic bcfg;
		logic wcfg;
	} rsf_flags_t;

	typedef struct packed {
		logic pc_clear;
		logic sp_clear;
		logic sp_top;
		logic int_disable;
		logic timer_off;
		logic wdt_clear;
		logic port_load;
		logic [7:0] port_data;
		logic [7:0] port_dir;
	} rsf_post_t;
endpackage : rsf_pkg

// >>> rsf_sync.sv
// Two-stage synchroniser for pin inputs of the reset-source flag block
`timescale 1ns/10ps
module rsf_sync
#(
	parameter int W = 1
)
(
	// Clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			q <= '0;
		end
		else if (ce)
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : rsf_sync

// >>> rsf_top.sv
// Reset-source flags, reset sequencer and post-reset state for the core
`timescale 1ns/10ps
`include "rsf_regs.svh"
//
// Function
// - Flag register keeps only bits 3..0; bits 7..4 read zero.
// - Brownout flag bit 2 set by brownout reset; only software zero clears.
// - Level-code corruption flag bit 1 set on bad code; software clears.
// - Writing 55h to flash control one resets the whole device.
// - Watchdog reset in run mode sets the timeout status.
// - Watchdog reset in low power clears PC and SP, sets both flags.
// - Timeout and power-down flags sit in status; power-on clears both.
// - Pin or brownout reset in run mode keeps timeout and power-down.
// - Watchdog run-mode reset sets timeout, keeps power-down.
// - Power-on starts at PC zero with every interrupt disabled.
// - Power-on clears watchdog and time bases, then watchdog runs.
// - Power-on switches every timer off.
// - Power-on makes ports inputs, data and direction all ones.
// - Power-on points the stack pointer at the stack top.
// - Reset-control corruption sets flag bit 3; only software clears.
// - Undefined level code resets after a delay, restoring the code.
module rsf_top
#(
	parameter logic [7:0] SRESET_CYCLES = `RSF_SRESET_CYC,
	parameter logic [7:0] LVR_QUAL_CYCLES = `RSF_LVR_QUAL_CYC,
	parameter logic [7:0] HOLD_CYCLES = `RSF_HOLD_CYC
)
(
	// Clock, reset, enable
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic CE,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Pins
	input wire logic EXT_RESET_PIN_N,
	input wire logic BROWNOUT_LOW,
	// Core events
	input wire logic WDT_TIMEOUT,
	input wire logic WDT_CFG_BAD,
	input wire logic LOW_POWER,
	input wire logic HALT_CMD,
	input wire logic WDT_CLR_CMD,
	// Reset outputs
	output logic CORE_RST,
	output rsf_pkg::rsf_kind_t RESET_KIND,
	output rsf_pkg::rsf_post_t POST_STATE,
	output logic WDT_RUN,
	output logic IRQ
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	rsf_pkg::rsf_seq_t seq_reg;
	rsf_pkg::rsf_kind_t kind_reg;
	rsf_pkg::rsf_kind_t start_kind;
	rsf_pkg::rsf_flags_t flags_reg;
	rsf_pkg::rsf_post_t post_reg;
	logic [7:0] cnt_reg, bor_cnt_reg, lvl_reg, rfc_reg, fc1_reg;
	logic [2:0] cause_reg;
	logic to_reg, pdf_reg, core_rst_reg, wdt_run_reg, irq_reg;
	logic [`RSF_IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_set;
	logic [31:0] prdata_reg, rd_next;
	logic pready_reg, pslverr_reg, map_hit, rd_flags_q;
	logic pin_n_s, bor_s, acc_first, wr_fire, start, soft_start;
	logic bor_en, bor_fire, iap_fire, lvl_bad, rfc_bad;
	logic wr_flags, full_reset;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic lvl_ok(input logic [7:0] c);
		lvl_ok = (c == 8'h66) || (c == 8'h55) || (c == 8'h33) || (c == 8'h99) ||
			(c == 8'haa) || (c == `RSF_LVL_OFF);
	endfunction : lvl_ok

	// Set beats the software clear; a written one keeps the old value
	function automatic logic flag_upd(input logic set, input logic old, input logic wr, input logic wbit);
		flag_upd = set || (wr ? (old && wbit) : old);
	endfunction : flag_upd

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	rsf_sync #(.W(2)) u_sync (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.ce(CE),
		.d({EXT_RESET_PIN_N, BROWNOUT_LOW}),
		.q({pin_n_s, bor_s})
	);

	// ----------------------------------------
	// APB decode and read path
	// ----------------------------------------
	assign acc_first = PSEL && PENABLE && !pready_reg;
	assign wr_fire = PSEL && PENABLE && pready_reg && PWRITE;
	assign wr_flags = wr_fire && (PADDR == `RSF_OFF_FLAGS);
	assign iap_fire = wr_fire && (PADDR == `RSF_OFF_FC1) && (PWDATA[7:0] == `RSF_FC1_KEY);

	always_comb
	begin
		rd_next = 32'h0;
		map_hit = 1'b1;
		case (PADDR)
			`RSF_OFF_FLAGS: rd_next = {28'h0, flags_reg};
			`RSF_OFF_STATUS: rd_next = {30'h0, pdf_reg, to_reg};
			`RSF_OFF_LVL: rd_next = {24'h0, lvl_reg};
			`RSF_OFF_RFC: rd_next = {24'h0, rfc_reg};
			`RSF_OFF_FC1: rd_next = {24'h0, fc1_reg};
			`RSF_OFF_IRQ_STAT: rd_next = {27'h0, irq_stat_reg};
			`RSF_OFF_IRQ_EN: rd_next = {27'h0, irq_en_reg};
			`RSF_OFF_IRQ_CLR: rd_next = 32'h0;
			`RSF_OFF_KIND: rd_next = {29'h0, kind_reg};
			default: map_hit = 1'b0;
		endcase
	end

	// One wait state: answer comes in the second access cycle
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
			rd_flags_q <= 1'b0;
		end
		else if (CE)
		begin
			pready_reg <= acc_first;
			pslverr_reg <= acc_first && !map_hit;
			prdata_reg <= (acc_first && !PWRITE) ? rd_next : 32'h0;
			rd_flags_q <= acc_first && !PWRITE && (PADDR == `RSF_OFF_FLAGS);
		end
	end

	// ----------------------------------------
	// Reset sources
	// ----------------------------------------
	assign lvl_bad = !lvl_ok(lvl_reg);
	assign rfc_bad = (rfc_reg != `RSF_RFC_IO) && (rfc_reg != `RSF_RFC_PIN);
	// Brownout detection is off when disabled by code or in sleep and idle
	assign bor_en = (lvl_reg != `RSF_LVL_OFF) && !lvl_bad && !LOW_POWER;
	assign bor_fire = bor_s && bor_en && (bor_cnt_reg == LVR_QUAL_CYCLES - 8'h01);

	// A short dip below the level is ignored
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			bor_cnt_reg <= 8'h0;
		else if (CE)
		begin
			if (!bor_s || !bor_en)
				bor_cnt_reg <= 8'h0;
			else if (bor_cnt_reg != LVR_QUAL_CYCLES)
				bor_cnt_reg <= bor_cnt_reg + 8'h01;
		end
	end

	// Priority among sources taken in the same cycle; none is taken during the hold
	always_comb
	begin
		start = 1'b0;
		start_kind = rsf_pkg::RSF_KIND_NONE;
		if (seq_reg != rsf_pkg::RSF_SEQ_HOLD)
		begin
			start = 1'b1;
			if (!pin_n_s && (rfc_reg == `RSF_RFC_PIN))
				start_kind = rsf_pkg::RSF_KIND_PIN;
			else if (bor_fire)
				start_kind = rsf_pkg::RSF_KIND_BOR;
			else if (WDT_TIMEOUT)
				start_kind = LOW_POWER ? rsf_pkg::RSF_KIND_WDT_SLEEP : rsf_pkg::RSF_KIND_WDT_RUN;
			else if (iap_fire)
				start_kind = rsf_pkg::RSF_KIND_IAP;
			else if ((seq_reg == rsf_pkg::RSF_SEQ_DELAY) && (cnt_reg == 8'h01))
				start_kind = rsf_pkg::RSF_KIND_SOFT;
			else
				start = 1'b0;
		end
	end

	assign soft_start = start && (start_kind == rsf_pkg::RSF_KIND_SOFT);
	assign full_reset = start && (start_kind != rsf_pkg::RSF_KIND_WDT_SLEEP);

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			seq_reg <= rsf_pkg::RSF_SEQ_HOLD;
			cnt_reg <= HOLD_CYCLES;
			kind_reg <= rsf_pkg::RSF_KIND_POR;
			cause_reg <= 3'h0;
			core_rst_reg <= 1'b1;
			wdt_run_reg <= 1'b0;
		end
		else if (CE)
		begin
			if (start)
			begin
				seq_reg <= rsf_pkg::RSF_SEQ_HOLD;
				cnt_reg <= HOLD_CYCLES;
				kind_reg <= start_kind;
				core_rst_reg <= 1'b1;
				wdt_run_reg <= 1'b0;
			end
			else
				case (seq_reg)
					rsf_pkg::RSF_SEQ_IDLE:
						if (lvl_bad || rfc_bad || WDT_CFG_BAD)
						begin
							seq_reg <= rsf_pkg::RSF_SEQ_DELAY;
							cnt_reg <= SRESET_CYCLES;
							cause_reg <= {rfc_bad, lvl_bad, WDT_CFG_BAD};
						end
					rsf_pkg::RSF_SEQ_DELAY:
						cnt_reg <= cnt_reg - 8'h01;
					rsf_pkg::RSF_SEQ_HOLD:
						if (cnt_reg <= 8'h01)
						begin
							seq_reg <= rsf_pkg::RSF_SEQ_IDLE;
							core_rst_reg <= 1'b0;
							wdt_run_reg <= 1'b1;
						end
						else
							cnt_reg <= cnt_reg - 8'h01;
					default:
						seq_reg <= rsf_pkg::RSF_SEQ_IDLE;
				endcase
		end
	end

	// ----------------------------------------
	// Post-reset state for the core
	// ----------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			post_reg <= '0;
			post_reg.pc_clear <= 1'b1;
			post_reg.int_disable <= 1'b1;
			post_reg.wdt_clear <= 1'b1;
			post_reg.timer_off <= 1'b1;
			post_reg.port_load <= 1'b1;
			post_reg.port_data <= `RSF_PORT_POR;
			post_reg.port_dir <= `RSF_PORT_POR;
			post_reg.sp_top <= 1'b1;
		end
		else if (CE)
		begin
			if (start && !full_reset)
			begin
				post_reg <= '0;
				post_reg.pc_clear <= 1'b1;
				post_reg.sp_clear <= 1'b1;
			end
			else if (full_reset)
			begin
				post_reg.pc_clear <= 1'b1;
				post_reg.sp_clear <= 1'b0;
				post_reg.sp_top <= 1'b1;
				post_reg.int_disable <= 1'b1;
				post_reg.timer_off <= 1'b1;
				post_reg.wdt_clear <= 1'b1;
				post_reg.port_load <= 1'b1;
				post_reg.port_data <= `RSF_PORT_POR;
				post_reg.port_dir <= `RSF_PORT_POR;
			end
			else if ((seq_reg == rsf_pkg::RSF_SEQ_HOLD) && (cnt_reg <= 8'h01))
				post_reg <= '0;
		end
	end

	// ----------------------------------------
	// Reset cause flags
	// ----------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			flags_reg <= '0;
		else if (CE)
		begin
			flags_reg.rcfg <= flag_upd(soft_start && cause_reg[2], flags_reg.rcfg, wr_flags,
				PWDATA[`RSF_BIT_RCFG]);
			flags_reg.bor <= flag_upd(start && (start_kind == rsf_pkg::RSF_KIND_BOR), flags_reg.bor,
				wr_flags, PWDATA[`RSF_BIT_BOR]);
			flags_reg.bcfg <= flag_upd(soft_start && cause_reg[1], flags_reg.bcfg, wr_flags,
				PWDATA[`RSF_BIT_BCFG]);
			flags_reg.wcfg <= flag_upd(soft_start && cause_reg[0], flags_reg.wcfg, wr_flags,
				PWDATA[`RSF_BIT_WCFG]);
		end
	end

	// ----------------------------------------
	// Timeout and power-down status
	// ----------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			to_reg <= 1'b0;
			pdf_reg <= 1'b0;
		end
		else if (CE)
		begin
			if (start && (start_kind == rsf_pkg::RSF_KIND_WDT_RUN))
				to_reg <= 1'b1;
			else if (start && (start_kind == rsf_pkg::RSF_KIND_WDT_SLEEP))
			begin
				to_reg <= 1'b1;
				pdf_reg <= 1'b1;
			end
			else if (start)
			begin
				to_reg <= to_reg;
				pdf_reg <= pdf_reg;
			end
			else if (WDT_CLR_CMD)
			begin
				to_reg <= 1'b0;
				pdf_reg <= 1'b0;
			end
			else if (HALT_CMD)
			begin
				to_reg <= 1'b0;
				pdf_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Level select, reset function control, flash control one
	// ----------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			lvl_reg <= `RSF_LVL_POR;
			rfc_reg <= `RSF_RFC_IO;
			fc1_reg <= 8'h0;
		end
		else if (CE)
		begin
			if (full_reset)
			begin
				// A real brownout keeps the chosen level
				if (start_kind != rsf_pkg::RSF_KIND_BOR)
					lvl_reg <= `RSF_LVL_POR;
				rfc_reg <= `RSF_RFC_IO;
				fc1_reg <= 8'h0;
			end
			else if (!start && wr_fire)
				case (PADDR)
					`RSF_OFF_LVL: lvl_reg <= PWDATA[7:0];
					`RSF_OFF_RFC: rfc_reg <= PWDATA[7:0];
					`RSF_OFF_FC1: fc1_reg <= PWDATA[7:0];
					default: fc1_reg <= fc1_reg;
				endcase
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	assign irq_set = start ? {start_kind == rsf_pkg::RSF_KIND_IAP, soft_start,
		(start_kind == rsf_pkg::RSF_KIND_WDT_RUN) || (start_kind == rsf_pkg::RSF_KIND_WDT_SLEEP),
		start_kind == rsf_pkg::RSF_KIND_BOR, start_kind == rsf_pkg::RSF_KIND_PIN} : 5'h0;

	// The output lags the status by one cycle so that it leaves a flip-flop
	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			irq_stat_reg <= 5'h0;
			irq_en_reg <= 5'h0;
			irq_reg <= 1'b0;
		end
		else if (CE)
		begin
			if (wr_fire && (PADDR == `RSF_OFF_IRQ_CLR))
				irq_stat_reg <= irq_set | (irq_stat_reg & ~PWDATA[`RSF_IRQ_W-1:0]);
			else
				irq_stat_reg <= irq_set | irq_stat_reg;
			if (wr_fire && (PADDR == `RSF_OFF_IRQ_EN))
				irq_en_reg <= PWDATA[`RSF_IRQ_W-1:0];
			irq_reg <= |(irq_stat_reg & irq_en_reg);
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign CORE_RST = core_rst_reg;
	assign RESET_KIND = kind_reg;
	assign POST_STATE = post_reg;
	assign WDT_RUN = wdt_run_reg;
	assign IRQ = irq_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	localparam int SOFT_MAX = 300;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN || !CE);

	hi_bits_zero_a:
	assert property (pready_reg && rd_flags_q |-> prdata_reg[31:4] == 28'h0) else $error("flag read upper bits");
	bor_flag_set_a:
	assert property (start && start_kind == rsf_pkg::RSF_KIND_BOR |=> flags_reg.bor && CORE_RST)
		else $error("brownout flag not set");
	bor_flag_keep_a:
	assert property ($fell(flags_reg.bor) |-> $past(wr_flags) && !$past(PWDATA[`RSF_BIT_BOR]))
		else $error("brownout flag cleared without zero write");
	lvl_restore_a:
	assert property (seq_reg == rsf_pkg::RSF_SEQ_IDLE && lvl_bad && !start
		|=> ##[0:SOFT_MAX] (lvl_reg == `RSF_LVL_POR && flags_reg.bcfg)) else $error("bad level not restored");
	iap_reset_a:
	assert property (iap_fire && seq_reg == rsf_pkg::RSF_SEQ_IDLE && !WDT_TIMEOUT && !bor_fire && pin_n_s
		|=> CORE_RST && RESET_KIND == rsf_pkg::RSF_KIND_IAP) else $error("key write gave no reset");
	wdt_run_to_a:
	assert property (start && start_kind == rsf_pkg::RSF_KIND_WDT_RUN |=> to_reg && $stable(pdf_reg))
		else $error("run watchdog status wrong");
	wdt_sleep_a:
	assert property (start && start_kind == rsf_pkg::RSF_KIND_WDT_SLEEP
		|=> to_reg && pdf_reg && POST_STATE.sp_clear && POST_STATE.pc_clear && !POST_STATE.port_load)
		else $error("sleep watchdog state wrong");
	pin_keeps_a:
	assert property (start && start_kind == rsf_pkg::RSF_KIND_PIN |=> $stable(to_reg) && $stable(pdf_reg))
		else $error("pin reset changed status");
	por_state_a:
	assert property ($rose(RSTN) |-> CORE_RST && !to_reg && !pdf_reg && POST_STATE.port_dir == 8'hff
		&& POST_STATE.sp_top && POST_STATE.timer_off && POST_STATE.int_disable) else $error("power-on state wrong");
	wdt_starts_a:
	assert property ($rose(RSTN) |-> ##4 WDT_RUN) else $error("watchdog not running after hold");

	wdt_sleep_c: cover property (start && start_kind == rsf_pkg::RSF_KIND_WDT_SLEEP);
	iap_c: cover property (iap_fire ##1 CORE_RST);
	soft_c: cover property (soft_start);
endmodule : rsf_top

// >>> reset_source_flags_bench.sv
// Self-checking bench for the reset-source flag block
`timescale 1ns/10ps
`include "rsf_regs.svh"
module reset_source_flags_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic pin_n = 1'b1, bo = 1'b0, wdt_to = 1'b0, wcfg_bad = 1'b0;
	logic low_pwr = 1'b0, halt = 1'b0, wclr = 1'b0, ce = 1'b1;
	logic [31:0] prdata, rd;
	logic pready, pslverr, core_rst, wdt_run, irq, err;
	rsf_pkg::rsf_kind_t kind, kind_s;
	rsf_pkg::rsf_post_t post, post_s;
	int n_errors = 0;
	int num_checks = 0;

	always #12.5 clk = ~clk;

	rsf_top dut (.CORE_CLK(clk), .RSTN(rstn), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EXT_RESET_PIN_N(pin_n), .BROWNOUT_LOW(bo), .WDT_TIMEOUT(wdt_to), .WDT_CFG_BAD(wcfg_bad),
		.LOW_POWER(low_pwr), .HALT_CMD(halt), .WDT_CLR_CMD(wclr), .CORE_RST(core_rst),
		.RESET_KIND(kind), .POST_STATE(post), .WDT_RUN(wdt_run), .IRQ(irq));

	// ----------------------------------------
	// Report and compare
	// ----------------------------------------
	task finish_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	task timeout;
		n_errors++;
		$display("BAD wait expected done seen timeout");
		finish_test();
	endtask : timeout

	task chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk_reg

	task chk_out(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD pin %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk_out

	// ----------------------------------------
	// Bus and event helpers
	// ----------------------------------------
	// Request held until the edge where pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		@(negedge clk);
		while (pready !== 1'b1)
		begin
			i++;
			if (i > 20)
				timeout();
			@(negedge clk);
		end
		rd = prdata;
		err = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk_reg(nm, exp, rd);
	endtask : rd_chk

	// Waits for core reset to reach v; kind and post state are captured on the rise only,
	// since post state returns to zero when the hold ends
	task wait_lvl(input logic v);
		int i;
		i = 0;
		@(negedge clk);
		while (core_rst !== v)
		begin
			i++;
			if (i > 200)
				timeout();
			@(negedge clk);
		end
		if (v)
		begin
			kind_s = kind;
			post_s = post;
		end
	endtask : wait_lvl

	task wdt_event;
		@(posedge clk);
		wdt_to <= 1'b1;
		@(posedge clk);
		wdt_to <= 1'b0;
		wait_lvl(1'b1);
		wait_lvl(1'b0);
	endtask : wdt_event

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk_out("core_rst", 32'h1, 32'(core_rst));
		chk_out("kind", 32'(rsf_pkg::RSF_KIND_POR), 32'(kind));
		chk_out("post", 32'h5fffff, 32'(post));
		wait_lvl(1'b0);
		chk_out("wdt_run", 32'h1, 32'(wdt_run));
		rd_chk("flags", `RSF_OFF_FLAGS, 32'h0);
		rd_chk("status", `RSF_OFF_STATUS, 32'h0);
		rd_chk("level", `RSF_OFF_LVL, 32'h66);
		rd_chk("control", `RSF_OFF_RFC, 32'h55);
		wr(`RSF_OFF_FLAGS, 32'hff);
		rd_chk("flags", `RSF_OFF_FLAGS, 32'h0);
		wdt_event();
		chk_out("kind", 32'(rsf_pkg::RSF_KIND_WDT_RUN), 32'(kind_s));
		rd_chk("status", `RSF_OFF_STATUS, 32'h1);
		@(posedge clk);
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		wr(`RSF_OFF_RFC, 32'haa);
		@(posedge clk);
		pin_n <= 1'b0;
		wait_lvl(1'b1);
		@(posedge clk);
		pin_n <= 1'b1;
		wait_lvl(1'b0);
		chk_out("kind", 32'(rsf_pkg::RSF_KIND_PIN), 32'(kind_s));
		rd_chk("status", `RSF_OFF_STATUS, 32'h2);
		rd_chk("control", `RSF_OFF_RFC, 32'h55);
		wr(`RSF_OFF_IRQ_CLR, 32'h1f);
		wr(`RSF_OFF_IRQ_EN, 32'h04);
		low_pwr <= 1'b1;
		wdt_event();
		low_pwr <= 1'b0;
		chk_out("kind", 32'(rsf_pkg::RSF_KIND_WDT_SLEEP), 32'(kind_s));
		chk_out("pc_sp", 32'h3, 32'({post_s.pc_clear, post_s.sp_clear}));
		rd_chk("status", `RSF_OFF_STATUS, 32'h3);
		rd_chk("irq_stat", `RSF_OFF_IRQ_STAT, 32'h04);
		chk_out("irq", 32'h1, 32'(irq));
		wr(`RSF_OFF_IRQ_EN, 32'h0);
		repeat (2) @(negedge clk);
		chk_out("irq", 32'h0, 32'(irq));
		wr(`RSF_OFF_IRQ_CLR, 32'h1f);
		rd_chk("irq_stat", `RSF_OFF_IRQ_STAT, 32'h0);
		@(posedge clk);
		bo <= 1'b1;
		wait_lvl(1'b1);
		@(posedge clk);
		bo <= 1'b0;
		wait_lvl(1'b0);
		chk_out("kind", 32'(rsf_pkg::RSF_KIND_BOR), 32'(kind_s));
		rd_chk("flags", `RSF_OFF_FLAGS, 32'h4);
		rd_chk("status", `RSF_OFF_STATUS, 32'h3);
		wr(`RSF_OFF_FLAGS, 32'h0f);
		rd_chk("flags", `RSF_OFF_FLAGS, 32'h4);
		wr(`RSF_OFF_FLAGS, 32'h0);
		rd_chk("flags", `RSF_OFF_FLAGS, 32'h0);
		wr(`RSF_OFF_LVL, 32'h12);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		chk_out("kind", 32'(rsf_pkg::RSF_KIND_SOFT), 32'(kind_s));
		rd_chk("flags", `RSF_OFF_FLAGS, 32'h2);
		rd_chk("level", `RSF_OFF_LVL, 32'h66);
		wr(`RSF_OFF_RFC, 32'h12);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		rd_chk("flags", `RSF_OFF_FLAGS, 32'ha);
		rd_chk("control", `RSF_OFF_RFC, 32'h55);
		@(posedge clk);
		wcfg_bad <= 1'b1;
		wait_lvl(1'b1);
		@(posedge clk);
		wcfg_bad <= 1'b0;
		wait_lvl(1'b0);
		rd_chk("flags", `RSF_OFF_FLAGS, 32'hb);
		wr(`RSF_OFF_FC1, 32'h55);
		wait_lvl(1'b1);
		chk_out("kind", 32'(rsf_pkg::RSF_KIND_IAP), 32'(kind_s));
		chk_out("core_rst", 32'h1, 32'(core_rst));
		wait_lvl(1'b0);
		rd_chk("kind_reg", `RSF_OFF_KIND, 32'(rsf_pkg::RSF_KIND_IAP));
		apb(1'b0, 8'h40, 32'h0);
		chk_reg("slverr", 32'h1, 32'(err));
		chk_reg("unmapped", 32'h0, rd);
		@(posedge clk);
		wclr <= 1'b1;
		@(posedge clk);
		wclr <= 1'b0;
		rd_chk("status", `RSF_OFF_STATUS, 32'h0);
		// While frozen a watchdog time-out must not be taken
		ce <= 1'b0;
		wdt_to <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk_out("frozen", 32'h0, 32'(core_rst));
		@(posedge clk);
		wdt_to <= 1'b0;
		ce <= 1'b1;
		rd_chk("status", `RSF_OFF_STATUS, 32'h0);
		finish_test();
	end
endmodule : reset_source_flags_bench
